/* rtl/wdt_wake_pkg.sv */
// Purpose: shared constants and carrier types for the watchdog and wake-up control
// Assumes: one system clock, configuration held on static input pins
// Notes: widths and counts live here so the block and its bench agree
package wdt_wake_pkg;

  // ----------------------------------------------------------------
  // software enable code
  // ----------------------------------------------------------------
  localparam logic [3:0] soft_disable_code = 4'h000a; // 1010 stops the watchdog
  localparam logic [3:0] soft_code_reset = 4'h000a;   // power-on value of the code

  // ----------------------------------------------------------------
  // divider chain and timing
  // ----------------------------------------------------------------
  localparam int chain_width = 16;          // longest division is 2^16
  localparam int min_div_exp = 13;          // shortest division is 2^13
  localparam int sys_div = 4;               // slow clock option is system clock / 4
  localparam int wake_delay_periods = 1024; // system clock periods after a port, interrupt or overflow wake
  localparam int irq_extra_cycles = 1;      // added before interrupt service entry

  // selectors on the configuration pins
  localparam logic src_sub = 1'b0;   // slow clock from the 32 kHz sub clock
  localparam logic src_sys = 1'b1;   // slow clock from the system clock / 4
  localparam logic clr_single = 1'b0;
  localparam logic clr_paired = 1'b1;

  // static configuration options grouped together
  typedef struct packed {
    logic wdt_allowed;       // configuration enables the watchdog function
    logic clock_source;      // src_sub or src_sys
    logic clear_mode;        // clr_single or clr_paired
    logic [1:0] period_sel;  // 0 -> 2^13 ... 3 -> 2^16
  } cfg_type;

  // instruction strobes from the decoder, one cycle each
  typedef struct packed {
    logic single_watchdog_clear_instr;
    logic paired_clear_first_instr;
    logic paired_clear_second_instr;
    logic halt;
  } instr_type;

  // wake-up phases
  typedef enum logic [1:0] {
    st_run,
    st_down,
    st_wait,
    st_irq
  } phase_type;

endpackage

/* rtl/wdt_wake_ctrl.sv */
// Purpose: watchdog timer with power-down wake-up control of an 8-bit controller core
// Assumes: inputs synchronous to clk_sys; slow clock tick arrives as a one-cycle strobe
// Notes: wake and overflow resets are one-cycle pulses, pin resets last while held low, all outputs registered except powered_down, decoded from the phase
//
// Functional notes
// RULE1 - counter clocked by sub clock or sysclk/4
// RULE2 - only code 1010 disables the watchdog
// RULE3 - enable code powers up as 1010
// RULE4 - function disabled: watchdog instructions do nothing
// RULE5 - time-out divides by 2^13 up to 2^16
// RULE6 - clear resets only the last divider stage
// RULE7 - overflow while running: device reset, time-out flag
// RULE8 - overflow while down: flag, reset pc and sp
// RULE9 - reset pin, clear instructions, halt clear count
// RULE10 - option picks single or paired clear
// RULE11 - paired clear needs both halves executed
// RULE12 - sysclk/4 source stops counting when down
// RULE13 - wake on reset, port fall, interrupt, overflow
// RULE14 - reset wake full reset, overflow wake watchdog reset
// RULE15 - down flag: cleared by power-up/clear, set by halt
// RULE16 - per-pin falling wake enable, resume after halt
// RULE17 - disabled or stack full: resume, keep pending
// RULE18 - enabled with stack room: normal interrupt response
// RULE19 - flag already set at halt cannot wake
// RULE20 - wait 1024 system clocks after any wake; the code skips the wait on a reset pin wake
// RULE21 - interrupt entry delayed one more cycle
// RULE22 - halt sets down flag, clears time-out flag
// RULE23 - halt clears watchdog; sysclk source stops it
// RULE24 - any device reset clears the whole chain
`timescale 1ns/1ps

module wdt_wake_ctrl #(
  parameter int port_width = 8,
  parameter int irq_count = 4,
  parameter int wake_delay = wdt_wake_pkg::wake_delay_periods
) (
  input wire logic clk_sys,
  input wire logic rst,                            // power-on reset
  input wire wdt_wake_pkg::cfg_type cfg,           // static configuration options
  input wire logic sub_tick,                       // one strobe per 32 kHz sub clock edge
  input wire logic external_reset_pin_n,           // low level resets the device
  input wire wdt_wake_pkg::instr_type instr,       // decoder strobes
  input wire logic [3:0] watchdog_soft_enable_code_wr, // new code value
  input wire logic watchdog_soft_enable_code_we,   // write strobe for the code
  input wire logic [port_width-1:0] port_pins,     // first-port pin levels
  input wire logic [port_width-1:0] port_wake_en,  // per-pin wake option
  input wire logic [irq_count-1:0] irq_req,        // interrupt request flags
  input wire logic [irq_count-1:0] irq_en,         // interrupt enables
  input wire logic stack_full,                     // no free stack level
  output logic [3:0] watchdog_soft_enable_code,    // current code readback
  output logic timeout_status_flag,
  output logic powerdown_status_flag,
  output logic powered_down,                       // core clock held
  output logic device_reset,                       // full reset pulse
  output logic pc_sp_reset,                        // pc and stack pointer reset pulse
  output logic resume_next,                        // pulse: run instruction after halt
  output logic irq_service,                        // pulse: take interrupt response
  output logic [15:0] wdt_count                    // divider chain readback
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (port_width < 1 || irq_count < 1 || wake_delay < 1 || wake_delay > 65535) begin : g_bad
    $error("wdt_wake_ctrl: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    wdt_wake_pkg::phase_type phase;            // run, down, wake wait, irq extra
    logic [15:0] chain;                        // watchdog divider chain
    logic [1:0] pre;                           // sysclk/4 prescaler
    logic [3:0] code;                          // software enable code
    logic pair_first;                          // first half of pair seen
    logic pair_second;                         // second half of pair seen
    logic to_flag;
    logic pd_flag;
    logic [port_width-1:0] pins_q;             // previous pin levels
    logic [irq_count-1:0] masked;              // requests set before halt
    logic [15:0] wait_cnt;                     // wake delay counter
    logic wake_irq;                            // wake came from an interrupt
    logic take_irq;                            // serve it after the wait
    logic dev_rst;
    logic pcsp_rst;
    logic resume;
    logic service;
  } state_type;

  state_type cur;        // registered state
  state_type next_cur;   // combinational next value

  // selected top bit of the chain for the chosen period
  function automatic logic tap_bit(input logic [15:0] c, input logic [1:0] sel);
    tap_bit = c[wdt_wake_pkg::min_div_exp - 1 + int'(sel)];
  endfunction

  // decoded helpers
  logic wdt_on;        // watchdog actually counting
  logic slow_tick;     // one watchdog clock tick
  logic overflow;      // chain reached the selected length
  logic sw_clear;      // clear instruction accepted
  logic [port_width-1:0] port_fall;
  logic [irq_count-1:0] new_irq;
  logic [16:0] chain_inc;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.dev_rst = 1'b0;
    next_cur.pcsp_rst = 1'b0;
    next_cur.resume = 1'b0;
    next_cur.service = 1'b0;
    next_cur.pins_q = port_pins;

    // only the exact code stops it; the option must allow it too
    wdt_on = cfg.wdt_allowed && (cur.code != wdt_wake_pkg::soft_disable_code); // see RULE2

    // slow clock: sys/4 prescaler halts with the core clock when down
    slow_tick = 1'b0;
    if (cfg.clock_source == wdt_wake_pkg::src_sub) begin
      slow_tick = sub_tick;                                              // see RULE1
    end else if (cur.phase != wdt_wake_pkg::st_down) begin
      next_cur.pre = cur.pre + 2'd1;                                     // see RULE12
      slow_tick = (cur.pre == 2'(wdt_wake_pkg::sys_div - 1));           // see RULE1
    end

    chain_inc = {1'b0, cur.chain} + 17'd1;
    overflow = wdt_on && slow_tick && tap_bit(cur.chain, cfg.period_sel) &&
               (cur.chain[wdt_wake_pkg::min_div_exp-2:0] ==
                {(wdt_wake_pkg::min_div_exp-1){1'b1}}) &&
               ((cur.chain >> (wdt_wake_pkg::min_div_exp - 1)) ==
                (16'hffff >> (wdt_wake_pkg::min_div_exp - 1 + 3 - int'(cfg.period_sel))));
    if (wdt_on && slow_tick) begin
      next_cur.chain = chain_inc[15:0];                                  // see RULE5
    end

    // software clears; all ignored when the function is off
    sw_clear = 1'b0;
    if (cfg.wdt_allowed) begin                                           // see RULE4
      if (cfg.clear_mode == wdt_wake_pkg::clr_single) begin
        sw_clear = instr.single_watchdog_clear_instr;                    // see RULE10
      end else begin
        // repeating the same half only re-marks it
        if (instr.paired_clear_first_instr) begin
          next_cur.pair_first = 1'b1;
        end
        if (instr.paired_clear_second_instr) begin
          next_cur.pair_second = 1'b1;
        end
        if (next_cur.pair_first && next_cur.pair_second) begin
          sw_clear = 1'b1;                                               // see RULE11
          next_cur.pair_first = 1'b0;
          next_cur.pair_second = 1'b0;
        end
      end
      if (watchdog_soft_enable_code_we) begin
        next_cur.code = watchdog_soft_enable_code_wr;
      end
    end
    if (sw_clear) begin
      // last stage only: residual low bits keep running
      next_cur.chain[15:wdt_wake_pkg::min_div_exp-1] = '0;               // see RULE6
      next_cur.pd_flag = 1'b0;                                           // see RULE15
    end

    port_fall = cur.pins_q & ~port_pins & port_wake_en;                  // see RULE16
    new_irq = irq_req & ~cur.masked;                                     // see RULE19

    case (cur.phase)
      wdt_wake_pkg::st_run: begin
        if (overflow) begin
          next_cur.dev_rst = 1'b1;                                       // see RULE7
          next_cur.to_flag = 1'b1;
          next_cur.chain = '0;                                           // see RULE24
        end else if (instr.halt) begin
          next_cur.phase = wdt_wake_pkg::st_down;
          next_cur.pd_flag = 1'b1;                                       // see RULE22
          next_cur.to_flag = 1'b0;
          next_cur.chain[15:wdt_wake_pkg::min_div_exp-1] = '0;           // see RULE23
          next_cur.masked = irq_req;                                     // see RULE19
        end
      end
      wdt_wake_pkg::st_down: begin
        next_cur.masked = cur.masked & irq_req;
        if (overflow) begin
          next_cur.to_flag = 1'b1;                                       // see RULE8
          next_cur.pcsp_rst = 1'b1;                                      // see RULE14
          next_cur.chain = '0;
          next_cur.phase = wdt_wake_pkg::st_wait;
          next_cur.wake_irq = 1'b0;
          next_cur.wait_cnt = '0;
        end else if ((|port_fall) || (|new_irq)) begin                   // see RULE13
          next_cur.phase = wdt_wake_pkg::st_wait;
          next_cur.wake_irq = |new_irq;
          // served only if enabled and stack has room, else stays pending
          next_cur.take_irq = (|(new_irq & irq_en)) && !stack_full;      // see RULE17
          next_cur.wait_cnt = '0;
        end
      end
      wdt_wake_pkg::st_wait: begin
        next_cur.wait_cnt = cur.wait_cnt + 16'd1;
        if (cur.wait_cnt == 16'(wake_delay - 1)) begin                   // see RULE20
          if (cur.wake_irq && cur.take_irq) begin
            next_cur.phase = wdt_wake_pkg::st_irq;                       // see RULE21
          end else begin
            next_cur.phase = wdt_wake_pkg::st_run;
            next_cur.resume = 1'b1;                                      // see RULE16
          end
        end
      end
      wdt_wake_pkg::st_irq: begin
        next_cur.phase = wdt_wake_pkg::st_run;
        next_cur.service = 1'b1;                                         // see RULE18
        next_cur.take_irq = 1'b0;
      end
      default: begin
        next_cur.phase = wdt_wake_pkg::st_run;
      end
    endcase

    // low level on the reset pin: full reset, count cleared, wakes if down
    if (!external_reset_pin_n) begin
      next_cur.phase = wdt_wake_pkg::st_run;                             // see RULE14
      next_cur.chain = '0;                                               // see RULE9
      next_cur.pre = '0;
      next_cur.dev_rst = 1'b1;
      next_cur.pair_first = 1'b0;
      next_cur.pair_second = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '0;                                                         // see RULE24
      cur.code <= wdt_wake_pkg::soft_code_reset;                         // see RULE3
      cur.phase <= wdt_wake_pkg::st_run;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state flops, except powered_down, decoded from the phase
  assign watchdog_soft_enable_code = cur.code;
  assign timeout_status_flag = cur.to_flag;
  assign powerdown_status_flag = cur.pd_flag;
  assign powered_down = (cur.phase != wdt_wake_pkg::st_run);
  assign device_reset = cur.dev_rst;
  assign pc_sp_reset = cur.pcsp_rst;
  assign resume_next = cur.resume;
  assign irq_service = cur.service;
  assign wdt_count = cur.chain;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_code_reset_val: assert property (@(posedge clk_sys) $fell(rst) |->
    cur.code == wdt_wake_pkg::soft_code_reset) else $error("code not 1010"); // see RULE3
  a_halt_flags: assert property (@(posedge clk_sys) disable iff (rst)
    cur.phase == wdt_wake_pkg::st_run && instr.halt && !overflow && external_reset_pin_n
    |=> cur.pd_flag && !cur.to_flag) else $error("halt flags wrong"); // see RULE22
  a_disabled_hold: assert property (@(posedge clk_sys) disable iff (rst)
    cur.code == wdt_wake_pkg::soft_disable_code |=> $stable(cur.chain) || $fell(rst)
    || !external_reset_pin_n || $past(instr.halt) || $past(sw_clear))
    else $error("chain moved while disabled"); // see RULE2
  a_func_off_nop: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg.wdt_allowed |=> $stable(cur.code)) else $error("code changed when off"); // see RULE4
  a_run_overflow: assert property (@(posedge clk_sys) disable iff (rst)
    cur.phase == wdt_wake_pkg::st_run && overflow |=> device_reset && timeout_status_flag)
    else $error("overflow no reset"); // see RULE7
  a_down_overflow: assert property (@(posedge clk_sys) disable iff (rst)
    cur.phase == wdt_wake_pkg::st_down && overflow && external_reset_pin_n
    |=> pc_sp_reset && !device_reset && timeout_status_flag)
    else $error("down overflow wrong"); // see RULE8
  a_sys_stop: assert property (@(posedge clk_sys) disable iff (rst)
    cfg.clock_source == wdt_wake_pkg::src_sys && cur.phase == wdt_wake_pkg::st_down
    |-> !slow_tick) else $error("counting while down"); // see RULE12
  a_pair_both: assert property (@(posedge clk_sys) disable iff (rst)
    cfg.clear_mode == wdt_wake_pkg::clr_paired && !cur.pair_second
    && !instr.paired_clear_second_instr |-> !sw_clear)
    else $error("pair cleared early"); // see RULE11
  a_irq_extra: assert property (@(posedge clk_sys) disable iff (rst)
    cur.phase == wdt_wake_pkg::st_irq && external_reset_pin_n |=> irq_service && !resume_next)
    else $error("irq entry not delayed"); // see RULE21

endmodule

/* sim/cpu_core_model.sv */
// Purpose: behavioural core seen by the watchdog block: decoder strobes and interrupt flags
// Assumes: strobes last one clock and change 1 ns after the rising edge
// Notes: counts every full reset and pc and stack pointer reset pulse so the bench can check them
`timescale 1ns/1ps

module cpu_core_model #(
  parameter int irq_count = 4
) (
  input wire logic clk_sys,
  input wire logic device_reset,
  input wire logic pc_sp_reset,
  input wire logic resume_next,
  input wire logic irq_service,
  output wdt_wake_pkg::instr_type instr,
  output logic [irq_count-1:0] irq_req
);
  // ----------------------------------------------------------------
  // pulse counters
  // ----------------------------------------------------------------
  int n_rst = 0; // full device resets seen
  int n_pc = 0; // pc and stack pointer resets seen

  initial begin
    instr = '0;
    irq_req = '0;
  end

  // request flags stay pending until the core really services an interrupt, which clears them all
  always @(posedge clk_sys) begin
    if (device_reset === 1'b1) begin
      n_rst++;
    end
    if (pc_sp_reset === 1'b1) begin
      n_pc++;
    end
    if (irq_service === 1'b1) begin
      #1 irq_req = '0;
    end
  end

  // op 0 single clear, 1 first half, 2 second half, 3 halt
  task automatic issue(input int op);
    @(posedge clk_sys);
    #1 instr = wdt_wake_pkg::instr_type'(4'b1000 >> op);
    @(posedge clk_sys);
    #1 instr = '0;
  endtask

  // sets or drops one interrupt request flag
  task automatic raise(input int i, input logic v);
    @(posedge clk_sys);
    #1 irq_req[i] = v;
  endtask
endmodule

/* sim/tb_wdt_wake_ctrl.sv */
// Purpose: self-checking bench for the watchdog and wake-up control
// Assumes: wake delay shortened to 8 cycles, sub tick held high so it ticks every clock
// Notes: overflow waits are bounded by the selected division, 2^13 or 2^14, plus margin
`timescale 1ns/1ps

module tb_wdt_wake_ctrl;
  localparam int wd = 8; // shortened wake delay
  logic clk_sys, rst, sub_tick, ext_reset_n, code_we, stack_full;
  wdt_wake_pkg::cfg_type cfg;
  wdt_wake_pkg::instr_type instr;
  logic [3:0] code_wr, code, irq_req, irq_en;
  logic [7:0] port_pins, port_wake_en;
  logic to_flag, pd_flag, powered_down, device_reset, pc_sp_reset, resume_next, irq_service;
  logic [15:0] wdt_count, snap;
  int n_mismatch, samples_checked, n, k0;

  wdt_wake_ctrl #(.wake_delay(wd)) uut (.clk_sys(clk_sys), .rst(rst), .cfg(cfg),
    .sub_tick(sub_tick), .external_reset_pin_n(ext_reset_n), .instr(instr),
    .watchdog_soft_enable_code_wr(code_wr), .watchdog_soft_enable_code_we(code_we),
    .port_pins(port_pins), .port_wake_en(port_wake_en), .irq_req(irq_req), .irq_en(irq_en),
    .stack_full(stack_full), .watchdog_soft_enable_code(code), .timeout_status_flag(to_flag),
    .powerdown_status_flag(pd_flag), .powered_down(powered_down), .device_reset(device_reset),
    .pc_sp_reset(pc_sp_reset), .resume_next(resume_next), .irq_service(irq_service),
    .wdt_count(wdt_count));

  cpu_core_model core (.clk_sys(clk_sys), .device_reset(device_reset),
    .pc_sp_reset(pc_sp_reset), .resume_next(resume_next), .irq_service(irq_service),
    .instr(instr), .irq_req(irq_req));

  // ----------------------------------------------------------------
  // clock, compare and wait tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs always move 1 ns after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic evt(input int s);
    case (s)
      0: evt = device_reset;
      1: evt = pc_sp_reset;
      2: evt = resume_next;
      default: evt = irq_service;
    endcase
  endfunction

  // bounded wait for one output pulse; k gives the cycles it took
  task automatic wait_evt(input int s, input int lim, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (evt(s) !== 1'b1 && k < lim);
    chk_bit(evt(s), 1'b1);
  endtask

  task automatic write_code(input logic [3:0] v);
    code_wr = v;
    code_we = 1'b1;
    cyc(1);
    code_we = 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // the whole run needs about 30k cycles, so 100k means a hang
  initial begin
    #500000;
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1'b1;
    cfg = '{1'b1, wdt_wake_pkg::src_sub, wdt_wake_pkg::clr_single, 2'd0};
    {sub_tick, ext_reset_n, code_we, code_wr, stack_full} = {3'b110, 4'h0, 1'b0};
    {port_pins, port_wake_en, irq_en} = {8'hff, 8'h01, 4'hf};
    cyc(5);
    rst = 1'b0;
    cyc(1);
    chk_vec(16'(code), 16'h000a);
    chk_vec(wdt_count, 16'h0000);
    chk_bit(to_flag | pd_flag | powered_down, 1'b0);
    cyc(20);
    chk_vec(wdt_count, 16'h0000);
    // with the function off a code write must not land
    cfg.wdt_allowed = 1'b0;
    write_code(4'h0);
    chk_vec(16'(code), 16'h000a);
    cfg.wdt_allowed = 1'b1;
    write_code(4'h5);
    chk_vec(16'(code), 16'h0005);
    cyc(4200);
    chk_bit(wdt_count[12], 1'b1);
    core.issue(0);
    chk_vec(16'(wdt_count[15:12]), 16'h0000);
    chk_bit(wdt_count[11:0] != 12'h000, 1'b1);
    // paired mode: repeating one half must not clear
    cfg.clear_mode = wdt_wake_pkg::clr_paired;
    cyc(4200);
    core.issue(1);
    core.issue(1);
    chk_bit(wdt_count[12], 1'b1);
    core.issue(2);
    chk_vec(16'(wdt_count[15:12]), 16'h0000);
    cfg.clear_mode = wdt_wake_pkg::clr_single;
    wait_evt(0, 9000, n);
    chk_bit(to_flag, 1'b1);
    write_code(4'h5);
    // halt, sub clock keeps counting, port pin wakes
    core.issue(3);
    chk_bit(powered_down & pd_flag, 1'b1);
    chk_bit(to_flag, 1'b0);
    chk_vec(16'(wdt_count[15:12]), 16'h0000);
    // no sub clock strobe, no count
    sub_tick = 1'b0;
    snap = wdt_count;
    cyc(4);
    chk_vec(wdt_count, snap);
    sub_tick = 1'b1;
    cyc(4);
    chk_bit(wdt_count != snap, 1'b1);
    port_pins = 8'hfe;
    wait_evt(2, 20, n);
    chk_vec(16'(n), 16'(wd + 1));
    port_pins = 8'hff;
    cyc(1);
    chk_bit(powered_down, 1'b0);
    core.issue(0);
    chk_bit(pd_flag, 1'b0);
    // system clock source freezes in power-down; enabled interrupt wakes
    cfg.clock_source = wdt_wake_pkg::src_sys;
    core.issue(3);
    snap = wdt_count;
    cyc(30);
    chk_vec(wdt_count, snap);
    core.raise(0, 1'b1);
    wait_evt(3, 20, n);
    chk_vec(16'(n), 16'(wd + 2));
    // disabled interrupt resumes after halt and stays pending
    irq_en = 4'h0;
    core.issue(3);
    core.raise(1, 1'b1);
    wait_evt(2, 20, n);
    chk_bit(irq_service | ~irq_req[1], 1'b0);
    core.raise(1, 1'b0);
    irq_en = 4'hf;
    // enabled interrupt but full stack: resume, request stays pending
    stack_full = 1'b1;
    core.issue(3);
    core.raise(3, 1'b1);
    wait_evt(2, 20, n);
    chk_bit(irq_service | ~irq_req[3], 1'b0);
    core.raise(3, 1'b0);
    stack_full = 1'b0;
    // a flag already set at halt cannot wake
    core.raise(2, 1'b1);
    core.issue(3);
    // pin 1 has no wake option, so its fall is ignored
    port_pins = 8'hfd;
    cyc(30);
    chk_bit(powered_down, 1'b1);
    port_pins = 8'hfc;
    wait_evt(2, 20, n);
    port_pins = 8'hff;
    core.raise(2, 1'b0);
    // overflow while down resets only pc and sp
    // longer period: needs at least 2^14 minus the residual low bits
    cfg.clock_source = wdt_wake_pkg::src_sub;
    cfg.period_sel = 2'd1;
    k0 = core.n_rst;
    core.issue(3);
    wait_evt(1, 17000, n);
    chk_bit(n > 12000, 1'b1);
    chk_bit(to_flag & pd_flag, 1'b1);
    chk_vec(16'(core.n_rst - k0), 16'h0000);
    wait_evt(2, 20, n);
    // external reset pin wakes with a full reset and clears the count
    core.issue(3);
    ext_reset_n = 1'b0;
    cyc(2);
    chk_bit(device_reset, 1'b1);
    chk_vec(wdt_count, 16'h0000);
    chk_bit(powered_down, 1'b0);
    ext_reset_n = 1'b1;
    cyc(2);
    test_done();
  end
endmodule
